// ---- core/ipc_codec.sv ----
// Isolated pulse port codec: SPI to pulse encoder, pulse to SPI decoder and port role control
// Assumes link comparators and SPI pins are asynchronous; wake detection done outside
`default_nettype none
`include "ipc_map.svh"
module ipc_codec
    import ipc_pkg::*;
#(
    parameter int BLOCK_CYC = `IPC_BLOCK_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic chain_mode_select,
    input wire logic port_a_link_select,
    input wire logic wake_a,
    input wire logic wake_b,
    input wire logic spi_csb_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic a_rx_pos,
    input wire logic a_rx_neg,
    input wire logic b_rx_pos,
    input wire logic b_rx_neg,
    output logic a_pulse_pos_pin,
    output logic a_pulse_neg_pin,
    output logic b_pulse_pos_pin,
    output logic b_pulse_neg_pin,
    output logic int_csb_n,
    output logic int_sdi,
    output logic int_sck,
    input wire logic int_read_active,
    input wire logic int_read_bit,
    output logic [1:0] link_state
);
    // ==========================================
    // Synchronisers
    logic [9:0] s1;
    logic [9:0] s2;
    logic [9:0] raw;
    assign raw = {chain_mode_select, port_a_link_select, wake_a, wake_b, spi_csb_n,
                  spi_sck, spi_sdi, a_rx_pos, a_rx_neg, b_rx_pos ^ 1'b0};
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            // Reset to idle pin levels, so no false select edge follows reset
            s1 <= 10'h030;
            s2 <= 10'h030;
        end else if (ce) begin
            s1 <= raw;
            s2 <= s1;
        end
    end
    logic bn1;
    logic bn2;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bn1 <= 1'b0;
            bn2 <= 1'b0;
        end else if (ce) begin
            bn1 <= b_rx_neg;
            bn2 <= bn1;
        end
    end
    logic chain;
    logic iso_a;
    logic wk_a;
    logic wk_b;
    logic csb_s;
    logic sck_s;
    logic sdi_s;
    assign chain = s2[9];
    assign iso_a = s2[8];
    assign wk_a = s2[7];
    assign wk_b = s2[6];
    assign csb_s = s2[5];
    assign sck_s = s2[4];
    assign sdi_s = s2[3];
    // ==========================================
    // Ports
    ipc_port_if pa ();
    ipc_port_if pb ();
    ipc_port_phy u_pa (
        .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .port(pa),
        .rx_pos(s2[2]), .rx_neg(s2[1]),
        .pos_drv(a_pulse_pos_pin), .neg_drv(a_pulse_neg_pin)
    );
    ipc_port_phy u_pb (
        .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .port(pb),
        .rx_pos(s2[0]), .rx_neg(bn2),
        .pos_drv(b_pulse_pos_pin), .neg_drv(b_pulse_neg_pin)
    );
    // ==========================================
    // Role state machine
    ipc_state_t state;
    ipc_state_t next_state;
    logic spi_mode;
    logic reversible;
    assign spi_mode = !iso_a;
    assign reversible = chain && iso_a;
    logic a_slave;
    assign a_slave = state == IPC_S_READY_A || state == IPC_S_ACT_A;
    ipc_pulse_t slv_rx;
    ipc_pulse_t mst_rx;
    assign slv_rx = a_slave ? pa.rx_pulse : pb.rx_pulse;
    assign mst_rx = a_slave ? pb.rx_pulse : pa.rx_pulse;
    logic [31:0] blk_cnt;
    logic blocked;
    assign blocked = blk_cnt != 32'h0;
    logic mst_long_neg;
    assign mst_long_neg = mst_rx == IPC_P_LNEG && !blocked;
    always_comb begin
        next_state = state;
        unique case (state)
            IPC_S_SLEEP: begin
                if (wk_a || wk_b) next_state = IPC_S_READY_A;
            end
            IPC_S_READY_A, IPC_S_READY_B: begin
                if (spi_mode) next_state = csb_s ? IPC_S_READY_A : IPC_S_ACT_A;
                else if (pa.rx_pulse == IPC_P_LNEG) next_state = IPC_S_ACT_A;
                else if (reversible && pb.rx_pulse == IPC_P_LNEG) next_state = IPC_S_ACT_B;
            end
            IPC_S_ACT_A, IPC_S_ACT_B: begin
                if (spi_mode) next_state = csb_s ? IPC_S_READY_A : IPC_S_ACT_A;
                else if (slv_rx == IPC_P_LPOS) next_state = a_slave ? IPC_S_READY_A : IPC_S_READY_B;
                else if (reversible && mst_long_neg)
                    next_state = a_slave ? IPC_S_ACT_B : IPC_S_ACT_A;
            end
            default: next_state = IPC_S_SLEEP;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) state <= IPC_S_SLEEP;
        else if (ce) state <= next_state;
    end
    assign link_state = state == IPC_S_SLEEP ? 2'h0 : (state == IPC_S_READY_A || state == IPC_S_READY_B) ? 2'h1 : 2'h2;
    // ==========================================
    // Holdoff after own transmission
    always_ff @(posedge ref_clk) begin
        if (!rstn) blk_cnt <= 32'h0;
        else if (ce) begin
            if (pa.tx_busy || pb.tx_busy) blk_cnt <= 32'(BLOCK_CYC);
            else if (blocked) blk_cnt <= blk_cnt - 32'h1;
        end
    end
    // ==========================================
    // Transmit requests
    logic csb_d;
    logic sck_d;
    logic wake_pend;
    logic in_sleep;
    assign in_sleep = state == IPC_S_SLEEP;
    ipc_pulse_t spi_ev;
    assign spi_ev = (csb_s && !csb_d) ? IPC_P_LPOS :
                    (!csb_s && csb_d) ? IPC_P_LNEG :
                    (sck_s && !sck_d && !csb_s) ? (sdi_s ? IPC_P_SPOS : IPC_P_SNEG) : IPC_P_NONE;
    ipc_pulse_t relay;
    // Roles follow the next state, so the pulse that picks a slave leaves on its master
    logic next_a_slave;
    assign next_a_slave = next_state == IPC_S_READY_A || next_state == IPC_S_ACT_A;
    assign relay = (state == IPC_S_ACT_A || state == IPC_S_ACT_B || next_state != state) &&
                   !spi_mode && !in_sleep ? (next_a_slave ? pa.rx_pulse : pb.rx_pulse) : IPC_P_NONE;
    logic reply;
    assign reply = !spi_mode && (slv_rx == IPC_P_SPOS || slv_rx == IPC_P_SNEG) &&
                   int_read_active && !int_read_bit;
    ipc_pulse_t spi_req;
    ipc_pulse_t master_req;
    ipc_pulse_t slave_req;
    // Wake pulse is owed in SPI mode too; host events go first
    assign spi_req = spi_mode ? spi_ev : IPC_P_NONE;
    assign master_req = spi_req != IPC_P_NONE ? spi_req : (wake_pend ? IPC_P_LPOS : relay);
    assign slave_req = reply ? IPC_P_SNEG : IPC_P_NONE;
    logic b_master;
    assign b_master = spi_mode || next_a_slave;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pa.tx_req <= IPC_P_NONE;
            pb.tx_req <= IPC_P_NONE;
        end else if (ce) begin
            pb.tx_req <= b_master ? master_req : (reversible ? slave_req : IPC_P_NONE);
            pa.tx_req <= spi_mode ? IPC_P_NONE : (b_master ? slave_req : master_req);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            csb_d <= 1'b1;
            sck_d <= 1'b1;
            wake_pend <= 1'b0;
        end else if (ce) begin
            csb_d <= csb_s;
            sck_d <= sck_s;
            if (in_sleep && wk_a && chain) begin
                wake_pend <= 1'b1;
            end else if (pb.tx_busy && wake_pend) begin
                wake_pend <= 1'b0;
            end
        end
    end
    // ==========================================
    // Internal SPI reconstruction
    logic mst_rx_zero;
    assign mst_rx_zero = pb.rx_pulse != IPC_P_SNEG;
    logic [1:0] sck_cnt;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            int_csb_n <= 1'b1;
            int_sdi <= 1'b0;
            int_sck <= 1'b1;
            sck_cnt <= 2'h0;
            spi_sdo <= 1'b1;
        end else if (ce) begin
            int_csb_n <= !(next_state == IPC_S_ACT_A || next_state == IPC_S_ACT_B);
            if (spi_mode && sck_s && !sck_d) begin
                int_sdi <= sdi_s;
                int_sck <= 1'b1;
            end else if (!spi_mode && (slv_rx == IPC_P_SPOS || slv_rx == IPC_P_SNEG)) begin
                int_sdi <= slv_rx == IPC_P_SPOS;
                int_sck <= 1'b0;
                sck_cnt <= 2'(`IPC_SCK_PULSE_CYC);
            end else if (sck_cnt != 2'h0) begin
                sck_cnt <= sck_cnt - 2'h1;
                if (sck_cnt == 2'h1) int_sck <= 1'b1;
            end else if (spi_mode) begin
                int_sck <= sck_s;
            end
            if (spi_mode && !mst_rx_zero) spi_sdo <= 1'b0;
            else if (spi_mode && sck_s && !sck_d) spi_sdo <= 1'b1;
        end
    end
    assign spi_sdo_oe_n = !(spi_mode && !spi_sdo && !csb_s);
    // ==========================================
    // Checks
    property p_sleep_reset;
        @(posedge ref_clk) $fell(rstn) ##1 1'b1 |-> state == IPC_S_SLEEP;
    endproperty
    a_sleep_reset: assert property (p_sleep_reset) else $error("not in sleep after reset");
    property p_slave_no_long;
        @(posedge ref_clk) disable iff (!rstn)
        (!spi_mode && !b_master) |=> pb.tx_req != IPC_P_LPOS && pb.tx_req != IPC_P_SPOS;
    endproperty
    a_slave_no_long: assert property (p_slave_no_long) else $error("slave sent long or plus");
    property p_csb_low_active;
        @(posedge ref_clk) disable iff (!rstn || !ce)
        (state == IPC_S_ACT_A || state == IPC_S_ACT_B) |-> !int_csb_n;
    endproperty
    a_csb_low_active: assert property (p_csb_low_active) else $error("select not low in active");
    property p_spi_csb_fall;
        @(posedge ref_clk) disable iff (!rstn || !ce)
        (spi_mode && $fell(csb_s)) |=> pb.tx_req == IPC_P_LNEG;
    endproperty
    a_spi_csb_fall: assert property (p_spi_csb_fall) else $error("no long minus on select fall");
    property p_block;
        @(posedge ref_clk) disable iff (!rstn)
        (blocked && !spi_mode && (state == IPC_S_ACT_A || state == IPC_S_ACT_B) &&
         slv_rx == IPC_P_NONE) |=> $stable(state);
    endproperty
    a_block: assert property (p_block) else $error("swap inside holdoff");
    c_wake: cover property (@(posedge ref_clk) in_sleep ##1 !in_sleep);
    c_swap: cover property (@(posedge ref_clk) state == IPC_S_ACT_A ##1 state == IPC_S_ACT_B);
    c_reply: cover property (@(posedge ref_clk) reply);
endmodule
`default_nettype wire

// ---- core/ipc_map.svh ----
// Timing and encoding constants for the pulse port codec
// Assumes a 200 MHz ref_clk (5 ns period)
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH
`define IPC_CLK_PS 5000
`define IPC_LONG_HALF_NS 150
`define IPC_SHORT_HALF_NS 50
`define IPC_LONG_HALF_CYC ((`IPC_LONG_HALF_NS * 1000) / `IPC_CLK_PS)
`define IPC_SHORT_HALF_CYC ((`IPC_SHORT_HALF_NS * 1000) / `IPC_CLK_PS)
`define IPC_FILT_NS 20
`define IPC_FILT_CYC (((`IPC_FILT_NS * 1000) + `IPC_CLK_PS - 1) / `IPC_CLK_PS)
`define IPC_WNDW_NS 40
`define IPC_WNDW_CYC ((`IPC_WNDW_NS * 1000) / `IPC_CLK_PS)
`define IPC_LONG_MIN_NS 100
`define IPC_LONG_MIN_CYC ((`IPC_LONG_MIN_NS * 1000) / `IPC_CLK_PS)
`define IPC_BLOCK_NS 2000
`define IPC_BLOCK_CYC ((`IPC_BLOCK_NS * 1000) / `IPC_CLK_PS)
`define IPC_SCK_PULSE_CYC 2
`endif

// ---- core/ipc_pkg.sv ----
// Types shared by the pulse port codec files
// Assumes nothing beyond the map header
`default_nettype none
package ipc_pkg;
    typedef enum logic [2:0] {
        IPC_P_NONE = 3'b000,
        IPC_P_LPOS = 3'b001,
        IPC_P_LNEG = 3'b010,
        IPC_P_SPOS = 3'b011,
        IPC_P_SNEG = 3'b100
    } ipc_pulse_t;
    typedef enum logic [1:0] {
        IPC_LV_ZERO = 2'b00,
        IPC_LV_POS = 2'b01,
        IPC_LV_NEG = 2'b10
    } ipc_level_t;
    typedef enum logic [2:0] {
        IPC_S_SLEEP = 3'b000,
        IPC_S_READY_A = 3'b001,
        IPC_S_READY_B = 3'b010,
        IPC_S_ACT_A = 3'b011,
        IPC_S_ACT_B = 3'b100
    } ipc_state_t;
endpackage
`default_nettype wire

// ---- core/ipc_port_if.sv ----
// Pulse request and received-pulse carrier for one link port
// Assumes one ref_clk domain
`default_nettype none
interface ipc_port_if;
    import ipc_pkg::*;
    ipc_pulse_t tx_req;
    logic tx_busy;
    logic tx_done;
    ipc_pulse_t rx_pulse;
    modport core (output tx_req, input tx_busy, input tx_done, input rx_pulse);
    modport phy (input tx_req, output tx_busy, output tx_done, output rx_pulse);
endinterface
`default_nettype wire

// ---- core/ipc_port_phy.sv ----
// One link port: pulse transmitter and receiver
// Assumes comparator inputs already synchronised
`default_nettype none
`include "ipc_map.svh"
module ipc_port_phy
    import ipc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    ipc_port_if.phy port,
    input wire logic rx_pos,
    input wire logic rx_neg,
    output logic pos_drv,
    output logic neg_drv
);
    // ==========================================
    // Transmitter
    logic [7:0] tx_cnt;
    logic tx_half;
    logic tx_first_pos;
    logic [7:0] tx_len;
    logic tx_start;
    assign tx_start = !port.tx_busy && port.tx_req != IPC_P_NONE;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            port.tx_busy <= 1'b0;
            port.tx_done <= 1'b0;
            tx_cnt <= 8'h00;
            tx_half <= 1'b0;
            tx_first_pos <= 1'b0;
            tx_len <= 8'h00;
        end else if (ce) begin
            port.tx_done <= 1'b0;
            if (tx_start) begin
                port.tx_busy <= 1'b1;
                tx_half <= 1'b0;
                tx_cnt <= 8'h00;
                tx_first_pos <= port.tx_req == IPC_P_LPOS || port.tx_req == IPC_P_SPOS;
                tx_len <= (port.tx_req == IPC_P_LPOS || port.tx_req == IPC_P_LNEG) ?
                    8'(`IPC_LONG_HALF_CYC) : 8'(`IPC_SHORT_HALF_CYC);
            end else if (port.tx_busy) begin
                if (tx_cnt == tx_len - 8'h01) begin
                    tx_cnt <= 8'h00;
                    tx_half <= 1'b1;
                    if (tx_half) begin
                        port.tx_busy <= 1'b0;
                        port.tx_done <= 1'b1;
                    end
                end else begin
                    tx_cnt <= tx_cnt + 8'h01;
                end
            end
        end
    end
    // Second half opposite to the first, zero when idle
    assign pos_drv = port.tx_busy && (tx_first_pos ^ tx_half);
    assign neg_drv = port.tx_busy && !(tx_first_pos ^ tx_half);
    // ==========================================
    // Receiver
    ipc_level_t lvl;
    ipc_level_t first_lvl;
    logic [7:0] run;
    logic [7:0] first_run;
    logic [7:0] gap;
    logic got_first;
    assign lvl = rx_pos ? IPC_LV_POS : (rx_neg ? IPC_LV_NEG : IPC_LV_ZERO);
    logic hold_ok;
    assign hold_ok = run >= 8'(`IPC_FILT_CYC);
    ipc_level_t prev_lvl;
    ipc_pulse_t next_rx;
    // Half accepted only past the filter; second half must follow inside window
    always_comb begin
        next_rx = IPC_P_NONE;
        if (got_first && lvl != prev_lvl && prev_lvl != IPC_LV_ZERO && prev_lvl != first_lvl &&
            hold_ok) begin
            if (first_run >= 8'(`IPC_LONG_MIN_CYC))
                next_rx = first_lvl == IPC_LV_POS ? IPC_P_LPOS : IPC_P_LNEG;
            else
                next_rx = first_lvl == IPC_LV_POS ? IPC_P_SPOS : IPC_P_SNEG;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prev_lvl <= IPC_LV_ZERO;
            run <= 8'h00;
            first_lvl <= IPC_LV_ZERO;
            first_run <= 8'h00;
            got_first <= 1'b0;
            gap <= 8'h00;
            port.rx_pulse <= IPC_P_NONE;
        end else if (ce) begin
            port.rx_pulse <= next_rx;
            prev_lvl <= lvl;
            if (lvl != prev_lvl) begin
                run <= 8'h01;
                gap <= 8'h00;
                if (next_rx != IPC_P_NONE) begin
                    got_first <= 1'b0;
                end else if (prev_lvl != IPC_LV_ZERO && hold_ok) begin
                    got_first <= 1'b1;
                    first_lvl <= prev_lvl;
                    first_run <= run;
                end
            end else begin
                if (run != 8'hff) run <= run + 8'h01;
                if (lvl == IPC_LV_ZERO && got_first) begin
                    gap <= gap + 8'h01;
                    if (gap >= 8'(`IPC_WNDW_CYC)) got_first <= 1'b0;
                end
                if (got_first && lvl != IPC_LV_ZERO && lvl == first_lvl) got_first <= 1'b0;
            end
        end
    end
    // ==========================================
    // Checks
    property p_tx_len;
        @(posedge ref_clk) disable iff (!rstn || !ce)
        $rose(port.tx_busy) |-> port.tx_busy [*8];
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("pulse too short");
    property p_idle_zero;
        @(posedge ref_clk) disable iff (!rstn)
        !port.tx_busy |-> !pos_drv && !neg_drv;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("line driven when idle");
    property p_exclusive;
        @(posedge ref_clk) disable iff (!rstn)
        !(pos_drv && neg_drv);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both drivers on");
endmodule
`default_nettype wire

// ---- bench/ipc_far_end.sv ----
// Far-end model of one pulse link port: sends pulses, decodes the codec's drive pins
// Assumes ref_clk at 200 MHz; comparator lines rest at zero when nothing is sent
`default_nettype none
module ipc_far_end
    import ipc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic drv_pos,
    input wire logic drv_neg,
    output var logic rx_pos,
    output var logic rx_neg,
    output var int n_rx,
    output var ipc_pulse_t last_rx,
    output var logic sym_bad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] lv;
    logic [1:0] first;
    logic [1:0] ph;
    int len1;
    int len2;
    ipc_pulse_t kind;
    initial begin
        rx_pos = 1'b0;
        rx_neg = 1'b0;
        n_rx = 0;
        last_rx = IPC_P_NONE;
        sym_bad = 1'b0;
        ph = 2'd0;
    end
    // ==========================================
    // Sender
    // Termination pulls a released pair to zero, so idle is 0/0
    task automatic send(input ipc_pulse_t p);
        int h;
        logic neg_first;
        h = (p == IPC_P_LPOS || p == IPC_P_LNEG) ? 30 : 10;
        neg_first = (p == IPC_P_LNEG || p == IPC_P_SNEG);
        @(negedge ref_clk);
        rx_pos = !neg_first;
        rx_neg = neg_first;
        repeat (h) @(negedge ref_clk);
        rx_pos = neg_first;
        rx_neg = !neg_first;
        repeat (h) @(negedge ref_clk);
        rx_pos = 1'b0;
        rx_neg = 1'b0;
    endtask
    // ==========================================
    // Decoder of the codec's drive pins
    // Threshold sits between the 10 and 30 cycle halves
    assign lv = {drv_neg, drv_pos};
    assign kind = (first == 2'b01) ? ((len1 >= 20) ? IPC_P_LPOS : IPC_P_SPOS)
                                   : ((len1 >= 20) ? IPC_P_LNEG : IPC_P_SNEG);
    always @(posedge ref_clk) begin
        case (ph)
            2'd0: begin
                if (lv != 2'b00) begin
                    first <= lv;
                    len1 <= 1;
                    ph <= 2'd1;
                end
            end
            2'd1: begin
                if (lv == first) begin
                    len1 <= len1 + 1;
                end else if (lv == (first ^ 2'b11)) begin
                    len2 <= 1;
                    ph <= 2'd2;
                end else begin
                    sym_bad <= 1'b1;
                    ph <= 2'd0;
                end
            end
            default: begin
                if (lv == (first ^ 2'b11)) begin
                    len2 <= len2 + 1;
                end else begin
                    if (lv != 2'b00 || len2 != len1) sym_bad <= 1'b1;
                    last_rx <= kind;
                    n_rx <= n_rx + 1;
                    ph <= 2'd0;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- bench/ipc_codec_tb_top.sv ----
// Testbench for the pulse port codec: SPI chain mode, pulse-link slave, replies, port swap
// Assumes one far-end model on each link port and a 200 MHz ref_clk
`default_nettype none
module ipc_codec_tb_top
    import ipc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BLOCK = 200;
    logic ref_clk, rstn, ce, chain_mode_select, port_a_link_select, wake_a, wake_b;
    logic spi_csb_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe_n, int_read_active, int_read_bit;
    logic a_rx_pos, a_rx_neg, b_rx_pos, b_rx_neg, int_csb_n, int_sdi, int_sck;
    logic a_pulse_pos_pin, a_pulse_neg_pin, b_pulse_pos_pin, b_pulse_neg_pin;
    logic [1:0] link_state;
    int n_a, n_b, base_a, base_b, num_errors, n_checks, cycles;
    ipc_pulse_t last_a, last_b;
    logic bad_a, bad_b, sck_seen, sdi_at_sck;
    ipc_codec #(.BLOCK_CYC(BLOCK)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
        .chain_mode_select(chain_mode_select), .port_a_link_select(port_a_link_select),
        .wake_a(wake_a), .wake_b(wake_b), .spi_csb_n(spi_csb_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n), .a_rx_pos(a_rx_pos), .a_rx_neg(a_rx_neg),
        .b_rx_pos(b_rx_pos), .b_rx_neg(b_rx_neg), .a_pulse_pos_pin(a_pulse_pos_pin),
        .a_pulse_neg_pin(a_pulse_neg_pin), .b_pulse_pos_pin(b_pulse_pos_pin),
        .b_pulse_neg_pin(b_pulse_neg_pin), .int_csb_n(int_csb_n), .int_sdi(int_sdi), .int_sck(int_sck),
        .int_read_active(int_read_active), .int_read_bit(int_read_bit), .link_state(link_state));
    ipc_far_end i_far_a (.ref_clk(ref_clk), .drv_pos(a_pulse_pos_pin), .drv_neg(a_pulse_neg_pin),
        .rx_pos(a_rx_pos), .rx_neg(a_rx_neg), .n_rx(n_a), .last_rx(last_a), .sym_bad(bad_a));
    ipc_far_end i_far_b (.ref_clk(ref_clk), .drv_pos(b_pulse_pos_pin), .drv_neg(b_pulse_neg_pin),
        .rx_pos(b_rx_pos), .rx_neg(b_rx_neg), .n_rx(n_b), .last_rx(last_b), .sym_bad(bad_b));
    // ==========================================
    // Clock, watchdog, internal clock capture
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    always @(posedge int_sck) begin
        sck_seen = 1'b1;
        sdi_at_sck = int_sdi;
    end
    // ==========================================
    // Helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Base is taken before stimulus: a relay may finish before the sender returns
    task automatic mark();
        base_a = n_a;
        base_b = n_b;
        sck_seen = 1'b0;
    endtask
    task automatic got(input bit on_b, input ipc_pulse_t exp);
        int k;
        k = 0;
        while ((on_b ? n_b == base_b : n_a == base_a) && k < 250) begin
            @(negedge ref_clk);
            k++;
        end
        check(on_b ? "pulse_b" : "pulse_a", {5'h0, on_b ? last_b : last_a}, {5'h0, exp});
    endtask
    task automatic none(input bit on_b, input int n);
        idle(n);
        check(on_b ? "quiet_b" : "quiet_a", 8'(on_b ? n_b - base_b : n_a - base_a), 8'h00);
    endtask
    task automatic do_reset(input logic lsel);
        @(negedge ref_clk);
        rstn = 1'b0;
        chain_mode_select = 1'b1;
        port_a_link_select = lsel;
        int_read_active = 1'b0;
        idle(10);
        rstn = 1'b1;
        idle(2);
    endtask
    task automatic wake(input bit on_b);
        int k;
        wake_a = !on_b;
        wake_b = on_b;
        idle(4);
        wake_a = 1'b0;
        wake_b = 1'b0;
        k = 0;
        while (link_state !== 2'h1 && k < 200) begin
            idle(1);
            k++;
        end
        check("ready", {6'h0, link_state}, 8'h01);
    endtask
    // Mode 3: clock idles high, data set while low, sampled on rise
    task automatic spi_bit(input logic b);
        @(negedge ref_clk);
        spi_sck = 1'b0;
        spi_sdi = b;
        idle(100);
        spi_sck = 1'b1;
        idle(100);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        check("state", {6'h0, link_state}, 8'h00);
        check("csb", {7'h0, int_csb_n}, 8'h01);
        check("pins", {4'h0, a_pulse_pos_pin, a_pulse_neg_pin, b_pulse_pos_pin, b_pulse_neg_pin}, 8'h00);
    endtask
    task automatic t_spi_chain();
        mark();
        wake(1'b0);
        got(1'b1, IPC_P_LPOS);
        mark();
        spi_csb_n = 1'b0;
        got(1'b1, IPC_P_LNEG);
        check("csb_low", {7'h0, int_csb_n}, 8'h00);
        mark();
        spi_bit(1'b1);
        got(1'b1, IPC_P_SPOS);
        mark();
        spi_bit(1'b0);
        got(1'b1, IPC_P_SNEG);
        check("sdo_silent", {7'h0, spi_sdo_oe_n}, 8'h01);
        i_far_b.send(IPC_P_SNEG);
        idle(10);
        check("sdo_zero", {6'h0, spi_sdo, spi_sdo_oe_n}, 8'h00);
        mark();
        spi_csb_n = 1'b1;
        got(1'b1, IPC_P_LPOS);
        mark();
        i_far_b.send(IPC_P_LNEG);
        none(1'b0, 150);
    endtask
    task automatic t_reverse();
        do_reset(1'b1);
        mark();
        wake(1'b1);
        none(1'b0, 150);
        mark();
        i_far_a.send(IPC_P_LNEG);
        got(1'b1, IPC_P_LNEG);
        check("active", {6'h0, link_state}, 8'h02);
        check("csb_low", {7'h0, int_csb_n}, 8'h00);
        mark();
        i_far_a.send(IPC_P_SPOS);
        got(1'b1, IPC_P_SPOS);
        check("sck", {6'h0, sck_seen, sdi_at_sck}, 8'h03);
        int_read_active = 1'b1;
        int_read_bit = 1'b0;
        mark();
        i_far_a.send(IPC_P_SNEG);
        got(1'b0, IPC_P_SNEG);
        check("sck0", {6'h0, sck_seen, sdi_at_sck}, 8'h02);
        int_read_bit = 1'b1;
        mark();
        i_far_a.send(IPC_P_SPOS);
        none(1'b0, 150);
        int_read_active = 1'b0;
    endtask
    task automatic t_swap();
        mark();
        i_far_a.send(IPC_P_SNEG);
        got(1'b1, IPC_P_SNEG);
        // Sent right after the relay, so it lands inside the holdoff
        i_far_b.send(IPC_P_LNEG);
        idle(20);
        mark();
        i_far_a.send(IPC_P_SPOS);
        got(1'b1, IPC_P_SPOS);
        idle(BLOCK + 50);
        i_far_b.send(IPC_P_LNEG);
        idle(150);
        mark();
        i_far_b.send(IPC_P_SPOS);
        got(1'b0, IPC_P_SPOS);
        check("sck_b", {6'h0, sck_seen, sdi_at_sck}, 8'h03);
        idle(20);
        i_far_b.send(IPC_P_LPOS);
        idle(100);
        check("csb_high", {7'h0, int_csb_n}, 8'h01);
        check("ready_again", {6'h0, link_state}, 8'h01);
        check("shape", {6'h0, bad_a, bad_b}, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        chain_mode_select = 1'b1;
        port_a_link_select = 1'b0;
        wake_a = 1'b0;
        wake_b = 1'b0;
        spi_csb_n = 1'b1;
        spi_sck = 1'b1;
        spi_sdi = 1'b0;
        int_read_active = 1'b0;
        int_read_bit = 1'b0;
        num_errors = 0;
        n_checks = 0;
        cycles = 0;
        do_reset(1'b0);
        t_reset();
        t_spi_chain();
        t_reverse();
        t_swap();
        finish_test();
    end
endmodule
`default_nettype wire
